// ---- rtl/nps_defs.svh ----
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH

`define NPS_CLK_NS 40
// Commands on the I/O bus, erased byte value, bad mark column and program limits
`define NPS_CMD_PTR_A 8'h00
`define NPS_CMD_PTR_B 8'h01
`define NPS_CMD_PTR_C 8'h50
`define NPS_CMD_PROG 8'h80
`define NPS_CMD_PROG_GO 8'h10
`define NPS_CMD_ERASE 8'h60
`define NPS_CMD_ERASE_GO 8'hd0
`define NPS_CMD_STATUS 8'h70
`define NPS_CMD_RESET 8'hff
`define NPS_ERASED 8'hff
`define NPS_BAD_COL 10'd517
`define NPS_SPARE_PROG_MAX 2
`define NPS_MAIN_PROG_MAX 1
// Strobe low and high phases, whole cycles
`define NPS_STB_LO 2
`define NPS_STB_HI 1
// Device busy limits in ns, their cycle counts, and the status fail bit
`define NPS_LOAD_NS 15000
`define NPS_RST_NS 5000
`define NPS_WB_NS 100
`define NPS_CEH_NS 100
`define NPS_BUSY_WAIT_NS 5000000
`define NPS_WB_CYC ((`NPS_WB_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_CEH_CYC ((`NPS_CEH_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_LOAD_CYC (`NPS_LOAD_NS / `NPS_CLK_NS)
`define NPS_BUSY_WAIT_CYC (`NPS_BUSY_WAIT_NS / `NPS_CLK_NS)
`define NPS_STATUS_FAIL_BIT 0

`endif

// ---- rtl/nps_host.sv ----
`timescale 1ns/1ps
`include "nps_defs.svh"
module nps_host
   import nps_pkg::*;
#(
   parameter int BUSY_WAIT = `NPS_BUSY_WAIT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic op_valid,
   output logic op_ready,
   input wire nps_op_e op_code,
   input wire nps_area_e op_area,
   input wire logic [7:0] op_col,
   input wire logic [25:9] op_row,
   input wire logic [7:0] wr_data,
   input wire logic [9:0] op_len,
   output logic [7:0] rd_data,
   output logic rd_strobe,
   output logic wr_take,
   output logic done,
   output logic fail,
   output logic refused,
   output logic bad_found,
   output logic [7:0] last_byte,
   output logic cle,
   output logic ale,
   output logic chip_sel_n,
   output logic write_strobe_n,
   output logic output_strobe_n,
   output logic [7:0] io_out,
   output logic io_oe,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);
   typedef enum logic [3:0] {
      NPS_IDLE, NPS_PTR, NPS_CMD, NPS_ADDR, NPS_DATA_W, NPS_GO,
      NPS_WAITB, NPS_WAITR, NPS_DATA_R, NPS_CEH, NPS_FIN
   } nps_st_e;

   localparam int NBLK = 4096;
   nps_st_e st;
   nps_op_e op;
   nps_area_e area;
   logic [7:0] col;
   logic [25:9] row;
   logic [9:0] len;
   logic [9:0] cnt;
   logic [2:0] acnt;
   logic [1:0] ph;
   logic [31:0] tmr;
   logic rb_s1, rb_s2;
   logic [7:0] io_s1, io_s2;
   logic [NBLK-1:0] bad_tbl;
   logic [1:0] prog_cnt;
   logic b_once;

   function automatic logic [7:0] ptr_cmd(input nps_area_e a);
      case (a)
         NPS_AREA_B: ptr_cmd = `NPS_CMD_PTR_B;
         NPS_AREA_C: ptr_cmd = `NPS_CMD_PTR_C;
         default: ptr_cmd = `NPS_CMD_PTR_A;
      endcase
   endfunction

   // Pin inputs are asynchronous to ref_clk
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
         io_s1 <= 8'h00;
         io_s2 <= 8'h00;
      end else begin
         rb_s1 <= ready_busy_n;
         rb_s2 <= rb_s1;
         io_s1 <= io_in;
         io_s2 <= io_s1;
      end
   end

   wire [11:0] blk = row[25:14];
   assign op_ready = (st == NPS_IDLE);
   // A strobe phase completes every STB_LO+STB_HI cycles
   wire ph_end = (ph == 2'(`NPS_STB_LO + `NPS_STB_HI - 1));

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st <= NPS_IDLE;
         op <= NPS_OP_READ;
         area <= NPS_AREA_A;
         col <= 8'h00;
         row <= '0;
         len <= '0;
         cnt <= '0;
         acnt <= '0;
         ph <= '0;
         tmr <= '0;
         done <= 1'b0;
         fail <= 1'b0;
         refused <= 1'b0;
         b_once <= 1'b0;
      end else begin
         done <= 1'b0;
         refused <= 1'b0;
         ph <= ph_end ? 2'd0 : ph + 2'd1;
         case (st)
            NPS_IDLE: begin
               ph <= '0;
               if (op_valid) begin
                  op <= op_code;
                  area <= op_area;
                  col <= op_col;
                  row <= op_row;
                  len <= op_len;
                  cnt <= '0;
                  acnt <= '0;
                  fail <= 1'b0;
                  if ((op_code == NPS_OP_PROG || op_code == NPS_OP_ERASE)
                      && bad_tbl[op_row[25:14]] && op_row[25:14] != 12'h0)
                     begin
                     refused <= 1'b1;
                     done <= 1'b1;
                  end else if (op_code == NPS_OP_PROG &&
                      (op_row == row ? prog_cnt : 2'd0) >=
                      2'(op_area == NPS_AREA_C ?
                      `NPS_SPARE_PROG_MAX : `NPS_MAIN_PROG_MAX)) begin
                     refused <= 1'b1;
                     done <= 1'b1;
                  end else if (op_code == NPS_OP_READ ||
                               op_code == NPS_OP_PROG)
                     st <= NPS_PTR;
                  else
                     st <= NPS_CMD;
               end
            end
            NPS_PTR: if (ph_end) begin
               b_once <= (area == NPS_AREA_B);
               st <= NPS_CMD;
            end
            NPS_CMD: if (ph_end) begin
               case (op)
                  NPS_OP_READ, NPS_OP_PROG: st <= NPS_ADDR;
                  NPS_OP_ERASE: begin
                     acnt <= 3'd1;
                     st <= NPS_ADDR;
                  end
                  NPS_OP_STATUS: st <= NPS_DATA_R;
                  default: begin
                     tmr <= '0;
                     st <= NPS_WAITB;
                  end
               endcase
            end
            NPS_ADDR: if (ph_end) begin
               acnt <= acnt + 3'd1;
               if (acnt == 3'd3)
                  st <= (op == NPS_OP_READ) ? NPS_WAITB :
                        (op == NPS_OP_PROG) ? NPS_DATA_W : NPS_GO;
               tmr <= '0;
            end
            NPS_DATA_W: if (ph_end) begin
               cnt <= cnt + 10'd1;
               if (cnt + 10'd1 == len)
                  st <= NPS_GO;
            end
            NPS_GO: if (ph_end) begin
               b_once <= 1'b0;
               tmr <= '0;
               st <= NPS_WAITB;
            end
            NPS_WAITB: begin
               // Device owes busy within the write-to-busy window
               tmr <= tmr + 32'd1;
               if (!rb_s2 || tmr >= 32'(`NPS_WB_CYC + 2)) begin
                  tmr <= '0;
                  st <= NPS_WAITR;
               end
            end
            NPS_WAITR: begin
               tmr <= tmr + 32'd1;
               if (rb_s2) begin
                  // Next strobe must start on a whole phase
                  ph <= '0;
                  if (op == NPS_OP_READ) begin
                     b_once <= 1'b0;
                     st <= NPS_DATA_R;
                  end else if (op == NPS_OP_PROG || op == NPS_OP_ERASE) begin
                     op <= NPS_OP_STATUS;
                     st <= NPS_CMD;
                  end else
                     st <= NPS_FIN;
               end else if (tmr >= 32'(BUSY_WAIT)) begin
                  fail <= 1'b1;
                  st <= NPS_FIN;
               end
            end
            NPS_DATA_R: if (ph_end) begin
               cnt <= cnt + 10'd1;
               if (op == NPS_OP_STATUS) begin
                  fail <= io_s2[`NPS_STATUS_FAIL_BIT];
                  st <= NPS_FIN;
               end else if (cnt + 10'd1 == len) begin
                  tmr <= '0;
                  st <= NPS_CEH;
               end
            end
            NPS_CEH: begin
               tmr <= tmr + 32'd1;
               if (tmr >= 32'(`NPS_CEH_CYC))
                  st <= NPS_FIN;
            end
            NPS_FIN: begin
               done <= 1'b1;
               st <= NPS_IDLE;
            end
            default: st <= NPS_IDLE;
         endcase
         if (st == NPS_IDLE && op_valid && op_code == NPS_OP_ABORT) begin
            tmr <= '0;
            st <= NPS_CEH;
         end
      end
   end

   // Bad mark detection and per-page program count; only the current page is tracked
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prog_cnt <= '0;
         bad_found <= 1'b0;
         last_byte <= 8'h00;
      end else begin
         bad_found <= 1'b0;
         if (st == NPS_IDLE && op_valid && op_code == NPS_OP_ERASE)
            prog_cnt <= '0;
         else if (st == NPS_IDLE && op_valid && op_row != row)
            prog_cnt <= '0;
         else if (st == NPS_GO && ph_end && op == NPS_OP_PROG)
            prog_cnt <= prog_cnt + 2'd1;
         if (st == NPS_DATA_R && ph_end && op != NPS_OP_STATUS)
            last_byte <= io_s2;
         // spare byte 517 on page 0 or 1
         if (st == NPS_DATA_R && ph_end && area == NPS_AREA_C &&
             row[13:10] == 4'h0 && {2'b10, col} + cnt == `NPS_BAD_COL &&
             io_s2 != `NPS_ERASED)
            bad_found <= 1'b1;
      end
   end

   // Only factory marks and failed status retire a block, never read data
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         bad_tbl <= '0;
      else if (bad_found && blk != 12'h000)
         bad_tbl[blk] <= 1'b1;
      else if (st == NPS_FIN && fail && op == NPS_OP_STATUS &&
               blk != 12'h000)
         bad_tbl[blk] <= 1'b1;
   end

   // Pin drive
   wire strobe_lo = (ph < 2'(`NPS_STB_LO));
   always_comb begin
      cle = (st == NPS_PTR || st == NPS_CMD || st == NPS_GO);
      ale = (st == NPS_ADDR);
      chip_sel_n = (st == NPS_IDLE || st == NPS_CEH || st == NPS_FIN);
      write_strobe_n = !(strobe_lo && (cle || ale || st == NPS_DATA_W));
      output_strobe_n = !(strobe_lo && st == NPS_DATA_R);
      io_oe = cle || ale || st == NPS_DATA_W;
      case (st)
         NPS_PTR: io_out = ptr_cmd(area);
         NPS_CMD: case (op)
            NPS_OP_PROG: io_out = `NPS_CMD_PROG;
            NPS_OP_ERASE: io_out = `NPS_CMD_ERASE;
            NPS_OP_STATUS: io_out = `NPS_CMD_STATUS;
            NPS_OP_RESET: io_out = `NPS_CMD_RESET;
            default: io_out = ptr_cmd(area);
         endcase
         NPS_ADDR: case (acnt)
            3'd0: io_out = col;
            3'd1: io_out = row[16:9];
            3'd2: io_out = row[24:17];
            default: io_out = {7'h00, row[25]};
         endcase
         NPS_DATA_W: io_out = wr_data;
         NPS_GO: io_out = (op == NPS_OP_ERASE) ? `NPS_CMD_ERASE_GO :
                          `NPS_CMD_PROG_GO;
         default: io_out = 8'h00;
      endcase
      rd_strobe = (st == NPS_DATA_R) && ph_end && op != NPS_OP_STATUS;
      wr_take = (st == NPS_DATA_W) && ph_end;
      rd_data = last_byte;
   end

   AST_PTR_B_FIRST: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st == NPS_CMD && op == NPS_OP_PROG && area == NPS_AREA_B) |->
      $past(st) inside {NPS_PTR, NPS_CMD})
      else $error("01h not right before 80h");
   AST_PTR_CODE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st == NPS_PTR && area == NPS_AREA_C) |-> io_out == 8'h50)
      else $error("wrong pointer code");
   AST_CEH: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(st == NPS_CEH) |-> chip_sel_n [*3])
      else $error("chip select high too short");
   AST_BAD_REFUSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st == NPS_IDLE && op_valid && op_code == NPS_OP_ERASE &&
       bad_tbl[op_row[25:14]] && op_row[25:14] != 12'h0) |=>
      refused && st == NPS_IDLE)
      else $error("erase of bad block not refused");
   AST_WAIT_BUSY: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st == NPS_WAITR && !rb_s2) |=> st != NPS_DATA_R)
      else $error("read data taken while busy");
   AST_PROG_CAP: assert property (@(posedge ref_clk) disable iff (!nrst)
      prog_cnt <= 2'd2)
      else $error("program count overflow");
   AST_B_ONCE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st == NPS_GO && ph_end) |=> !b_once)
      else $error("area B pointer kept");
   AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      done |=> (!done || refused))
      else $error("done longer than one cycle");
   COV_PROG: cover property (@(posedge ref_clk) st == NPS_GO && ph_end);
   COV_READ: cover property (@(posedge ref_clk) st == NPS_CEH);
   COV_BAD: cover property (@(posedge ref_clk) bad_found);
endmodule

// ---- rtl/nps_pkg.sv ----
package nps_pkg;
   typedef enum logic [2:0] {
      NPS_OP_READ,
      NPS_OP_PROG,
      NPS_OP_ERASE,
      NPS_OP_RESET,
      NPS_OP_STATUS,
      NPS_OP_ABORT
   } nps_op_e;
   typedef enum logic [1:0] {
      NPS_AREA_A,
      NPS_AREA_B,
      NPS_AREA_C
   } nps_area_e;
endpackage

// ---- tb/nps_flash_model.sv ----
`timescale 1ns/1ps
module nps_flash_model
   import nps_pkg::*;
#(
   parameter int BAD_BLK = 3
) (
   input wire logic cle,
   input wire logic ale,
   input wire logic chip_sel_n,
   input wire logic write_strobe_n,
   input wire logic output_strobe_n,
   input wire logic [7:0] io_out,
   input wire logic io_oe,
   input wire logic fail_next,
   output logic [7:0] io_in,
   output logic ready_busy_n,
   output logic host_err
);
   logic [7:0] mem [int];
   logic [7:0] pbuf [int];
   int pc [int];
   nps_area_e area = NPS_AREA_A;
   logic [7:0] last_cmd = 8'h00;
   logic [7:0] dout = 8'h00;
   logic drv = 0, loading = 0, st_fail = 0;
   int col = 0, pcol = 0, row = 0, n = 0, busy_ns = 0;
   event ev_busy;
   // Released bus shows the inverse so a stale byte never passes as read
   assign io_in = io_oe ? io_out : (drv ? dout : ~dout);
   initial begin
      host_err = 0;
      ready_busy_n = 1;
      mem[BAD_BLK * 32768 + 517] = 8'h00;
   end
   function automatic int rk(int c);
      return (row & 32'h0001ffff) * 1024 + c;
   endfunction
   task automatic go(int ns, logic ld);
      busy_ns = ns;
      loading = ld;
      if (area == NPS_AREA_B) area = NPS_AREA_A;
      -> ev_busy;
   endtask
   task automatic do_prog();
      int key = rk(0) / 512 + (pcol >= 512);
      pc[key] = pc.exists(key) ? pc[key] + 1 : 1;
      if (pc[key] > (pcol >= 512 ? 2 : 1)) host_err = 1;
      st_fail = fail_next;
      if (!fail_next) foreach (pbuf[c]) mem[rk(c)] = pbuf[c];
      go(2000, 0);
   endtask
   task automatic do_erase();
      int q [$];
      foreach (mem[k]) if (k / 32768 == rk(0) / 32768) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
      st_fail = 0;
      go(3000, 0);
   endtask
   always @(posedge write_strobe_n) if (!chip_sel_n) begin
      if (cle) begin
         case (io_out)
            8'h00: area = NPS_AREA_A;
            8'h01: area = NPS_AREA_B;
            8'h50: area = NPS_AREA_C;
            8'h80: begin
               pbuf.delete();
               if (!(last_cmd inside {8'h00, 8'h01, 8'h50}))
                  host_err = 1;
            end
            8'h10: do_prog();
            8'hd0: do_erase();
            8'hff: go(3000, 0);
            default: ;
         endcase
         last_cmd = io_out;
         n = 0;
      end else if (ale) begin
         if (last_cmd == 8'h60) row[8 * n +: 8] = io_out;
         else if (n == 0) begin
            col = area == NPS_AREA_C ? 512 + io_out[3:0] : io_out;
            if (area == NPS_AREA_B) col += 256;
            pcol = col;
         end else row[8 * (n - 1) +: 8] = io_out;
         n++;
         if (n == 4 && last_cmd != 8'h80) go(4000, 1);
      end else begin
         pbuf[col] = io_out;
         col++;
      end
   end
   always begin
      @(ev_busy);
      #50 ready_busy_n = 0;
      for (int t = 0; t < busy_ns; t += 10) begin
         #10;
         if (loading && chip_sel_n) break;
      end
      ready_busy_n = 1;
      loading = 0;
   end
   always @(negedge output_strobe_n) if (!chip_sel_n) begin
      #25;
      if (last_cmd == 8'h70) dout = {1'b1, ready_busy_n, 5'h00, st_fail};
      else dout = mem.exists(rk(col)) ? mem[rk(col)] : 8'hff;
      drv = 1;
      if (last_cmd != 8'h70) col++;
   end
   always @(posedge output_strobe_n) #30 drv = 0;
   // Reading past the last column starts loading the next page
   always @(posedge output_strobe_n)
      if (!chip_sel_n && last_cmd != 8'h70 && col >= 528) begin
         row++;
         col = area == NPS_AREA_C ? 512 : 0;
         go(4000, 1);
      end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import nps_pkg::*;
   localparam int BAD_BLK = 3;
   logic ref_clk = 0, nrst = 0, op_valid = 0, fail_next = 0, strb_d = 0;
   nps_op_e op_code = NPS_OP_READ;
   nps_area_e op_area = NPS_AREA_A;
   logic [7:0] op_col = 8'h00, wr_data = 8'h00;
   logic [16:0] op_row = 17'h00000;
   logic [9:0] op_len = 10'h000;
   logic [7:0] rd_data, last_byte, io_out, io_in;
   logic op_ready, rd_strobe, wr_take, done, fail, refused, bad_found;
   logic cle, ale, chip_sel_n, write_strobe_n, output_strobe_n, io_oe;
   logic ready_busy_n, host_err;
   int n_errors = 0, checks = 0, cyc = 0, nbad = 0;
   logic [7:0] exp_mem [int];
   logic [7:0] wq [$];
   logic [7:0] got_q [$];

   nps_host #(.BUSY_WAIT(200)) nps_host_i (
      .ref_clk, .nrst, .op_valid, .op_ready, .op_code, .op_area, .op_col,
      .op_row, .wr_data, .op_len, .rd_data, .rd_strobe, .wr_take, .done,
      .fail, .refused, .bad_found, .last_byte, .cle, .ale, .chip_sel_n,
      .write_strobe_n, .output_strobe_n, .io_out, .io_oe, .io_in,
      .ready_busy_n
   );
   nps_flash_model #(.BAD_BLK(BAD_BLK)) nps_flash_model_i (
      .cle, .ale, .chip_sel_n, .write_strobe_n, .output_strobe_n, .io_out,
      .io_oe, .fail_next, .io_in, .ready_busy_n, .host_err
   );

   initial forever #20 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (strb_d) got_q.push_back(rd_data);
      strb_d <= rd_strobe === 1'b1;
      if (bad_found === 1'b1) nbad++;
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   // Next write byte must be in place one cycle after each take
   always @(posedge ref_clk) if (wr_take === 1'b1) begin
      #2 void'(wq.pop_front());
      wr_data = wq.size() > 0 ? wq[0] : 8'h00;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic int base(nps_area_e ar, int c);
      return ar == NPS_AREA_A ? c : ar == NPS_AREA_B ? 256 + c : 512 + c % 16;
   endfunction
   function automatic logic [7:0] ev(int k);
      return exp_mem.exists(k) ? exp_mem[k] : 8'hff;
   endfunction
   task automatic run(nps_op_e op, nps_area_e ar, int c, int r, int len,
                      logic e_ref, logic e_fail);
      int k = 0;
      got_q.delete();
      nbad = 0;
      op_code = op;
      op_area = ar;
      op_col = 8'(c);
      op_row = 17'(r);
      op_len = 10'(len);
      wr_data = wq.size() > 0 ? wq[0] : 8'h00;
      op_valid = 1;
      @(posedge ref_clk);
      #2 op_valid = 0;
      while (done !== 1'b1 && k < 1000) begin
         @(posedge ref_clk);
         #2 k++;
      end
      chk("done", 8'h01, 8'(k < 1000));
      chk("refused", 8'(e_ref), 8'(refused));
      chk("fail", 8'(e_fail), 8'(fail));
   endtask
   task automatic prog(nps_area_e ar, int c, int r, int len, logic e_ref,
                       logic e_fail);
      logic [7:0] d [$];
      for (int i = 0; i < len; i++) d.push_back(8'($urandom));
      wq = d;
      run(NPS_OP_PROG, ar, c, r, len, e_ref, e_fail);
      if (!e_ref && !e_fail)
         foreach (d[i]) exp_mem[r * 1024 + base(ar, c) + i] = d[i];
   endtask
   task automatic rd(nps_area_e ar, int c, int r, int len, int e_bad);
      run(NPS_OP_READ, ar, c, r, len, 0, 0);
      chk("rd_count", 8'(len), 8'(got_q.size()));
      foreach (got_q[i])
         chk("rd_data", ev(r * 1024 + base(ar, c) + i), got_q[i]);
      chk("bad_found", 8'(e_bad), 8'(nbad));
   endtask

   initial begin
      void'($urandom(41076));
      exp_mem[BAD_BLK * 32768 + 517] = 8'h00;
      repeat (20) @(posedge ref_clk);
      #2 nrst = 1;
      for (int a = 0; a < 3; a++) begin
         automatic int c = $urandom % (a == 2 ? 10 : 250);
         prog(nps_area_e'(a), c, 160 + a, 6, 0, 0);
         rd(nps_area_e'(a), c, 160 + a, 6, 0);
      end
      $display("test pointer areas done");
      prog(NPS_AREA_C, 0, 170, 4, 0, 0);
      prog(NPS_AREA_C, 8, 170, 4, 0, 0);
      prog(NPS_AREA_C, 12, 170, 2, 1, 0);
      prog(NPS_AREA_A, 0, 171, 8, 0, 0);
      prog(NPS_AREA_B, 0, 171, 8, 1, 0);
      rd(NPS_AREA_C, 0, 170, 16, 0);
      chk("ready_busy_n", 8'h01, 8'(ready_busy_n));
      $display("test partial program limits done");
      rd(NPS_AREA_C, 5, BAD_BLK * 32, 1, 1);
      prog(NPS_AREA_A, 0, BAD_BLK * 32 + 4, 4, 1, 0);
      run(NPS_OP_ERASE, NPS_AREA_A, 0, BAD_BLK * 32, 0, 1, 0);
      prog(NPS_AREA_A, 0, 2, 4, 0, 0);
      fail_next = 1;
      prog(NPS_AREA_A, 0, 3, 4, 0, 1);
      fail_next = 0;
      prog(NPS_AREA_A, 0, 4, 4, 0, 0);
      $display("test bad block done");
      prog(NPS_AREA_A, 0, 200, 8, 0, 0);
      fail_next = 1;
      prog(NPS_AREA_A, 0, 201, 8, 0, 1);
      fail_next = 0;
      rd(NPS_AREA_A, 0, 200, 8, 0);
      prog(NPS_AREA_A, 0, 202, 4, 1, 0);
      $display("test program failure done");
      prog(NPS_AREA_A, 9, 227, 5, 0, 0);
      run(NPS_OP_ERASE, NPS_AREA_A, 0, 224, 0, 0, 0);
      for (int i = 0; i < 528; i++)
         if (exp_mem.exists(227 * 1024 + i)) exp_mem.delete(227 * 1024 + i);
      rd(NPS_AREA_A, 9, 227, 5, 0);
      $display("test erase done");
      run(NPS_OP_RESET, NPS_AREA_A, 0, 0, 0, 0, 0);
      run(NPS_OP_STATUS, NPS_AREA_A, 0, 0, 0, 0, 0);
      run(NPS_OP_ABORT, NPS_AREA_A, 0, 0, 0, 0, 0);
      rd(NPS_AREA_A, 0, 160, 4, 0);
      prog(NPS_AREA_A, 0, 163, 4, 0, 0);
      chk("host_err", 8'h00, 8'(host_err));
      $display("test reset status abort done");
      print_verdict();
   end
endmodule
